// ===== logic/spimsp_map.svh
`ifndef SPIMSP_MAP_SVH
`define SPIMSP_MAP_SVH
// Baud divisor: SCK period is 2*divisor clocks, fastest legal divisor is 2 (clk/4)
`define SPIMSP_BAUD_MIN 16'h0002
`define SPIMSP_BAUD_RESET 16'h0002
`define SPIMSP_LEN_8 5'h08
`define SPIMSP_LEN_16 5'h10
`define SPIMSP_FIFO_DEPTH 4
`define SPIMSP_FIFO_AW 2
`define SPIMSP_WORD_W 16
`define SPIMSP_SEL_W 7
`define SPIMSP_SEL_IDLE 7'h7F
`define SPIMSP_CNT_RESET 16'h0000
`endif

// ===== logic/spimsp_pkg.sv
package spimsp_pkg;
	typedef enum logic [1:0]
	{
		SPIMSP_IDLE = 2'b00,
		SPIMSP_LEAD = 2'b01,
		SPIMSP_TRAIL = 2'b10,
		SPIMSP_DONE = 2'b11
	} spimsp_state_t;

	typedef struct packed
	{
		logic enable;
		logic master;
		logic word16;
		logic cpol;
		logic cpha;
		logic dma_en;
		logic dma_rx_irq;
	} spimsp_cfg_t;

	typedef struct packed
	{
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic sck_o;
		logic sck_oe;
	} spimsp_pins_t;
endpackage : spimsp_pkg

// ===== logic/spimsp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module spimsp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4,
	parameter int AW = 2
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic do_wr;
	logic do_rd;

	assign in_ready = (cnt_reg < (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign out_data = mem_reg[rd_reg];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (do_wr)
				wr_reg <= wr_reg + 1'b1;
			if (do_rd)
				rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// Storage is not reset; out_valid guards stale words
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem_reg[wr_reg] <= in_data;
	end
endmodule : spimsp_fifo
`default_nettype wire

// ===== logic/spimsp_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module spimsp_shifter
	import spimsp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic load,
	input wire logic [15:0] load_data,
	input wire logic word16,
	input wire logic sample,
	input wire logic launch,
	input wire logic serial_in,
	// Results
	output logic serial_out,
	output logic [15:0] rx_word
);
	logic [15:0] sh_reg;
	logic [15:0] rx_reg;
	logic [15:0] sh_next;
	logic [15:0] rx_next;

	// MSB first; an 8-bit word sits in the low byte and leaves from bit 7
	assign serial_out = word16 ? sh_reg[15] : sh_reg[7];
	assign sh_next = {sh_reg[14:0], 1'b0};
	// Receive has its own register so the last sample is in place in either phase
	assign rx_next = word16 ? {rx_reg[14:0], serial_in} : {8'h00, rx_reg[6:0], serial_in};
	assign rx_word = rx_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sh_reg <= 16'h0000;
			rx_reg <= 16'h0000;
		end
		else
		begin
			if (sample)
				rx_reg <= rx_next;
			if (load)
				sh_reg <= load_data;
			else if (launch)
				sh_reg <= sh_next;
		end
	end
endmodule : spimsp_shifter
`default_nettype wire

// ===== logic/spimsp_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "spimsp_map.svh"
// Functional notes
// - Master drives SCK, or slave follows it
// - Master SCK from 16-bit divisor, fastest clk/4
// - Word length selectable 8 or 16 bits
// - Clock polarity and phase configurable
// - Broadcast: several slave selects at once
// - Slave select input shares flag line zero
// - Seven slave select outputs on flags 1-7
// - Full duplex shift, SCK times both
// - Master emits programmed pulses, MOSI/MISO concurrent
// - DMA runs until word count 1 to 0
// - Slave shifts only while selected
// - Slave sends zero word on underrun
// - DMA descriptors live in I/O page zero
// - Non-DMA uses core buffer write and read
// - Own interrupt; receive-complete descriptor interrupt
// - DMA continues with next queued descriptor
module spimsp_port
	import spimsp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration
	input wire spimsp_cfg_t cfg,
	input wire logic [15:0] baud_div,
	input wire logic [6:0] sel_enable,
	input wire logic [6:0] sel_assert,
	input wire logic flag0_is_select,
	// Core transmit buffer
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [15:0] tx_data,
	// Core receive buffer
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [15:0] rx_data,
	// DMA descriptor queue
	input wire logic desc_valid,
	output logic desc_ready,
	input wire logic [15:0] desc_count,
	output logic [15:0] dma_count,
	output logic dma_busy,
	// Status
	output logic busy,
	output logic irq_word,
	output logic irq_desc_done,
	output logic rx_overrun,
	// Serial pins
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	output spimsp_pins_t pins,
	// Flag pins
	input wire logic flag_line_zero,
	output logic [6:0] flag_lines_one_to_seven,
	output logic [6:0] flag_lines_one_to_seven_oe
);
	spimsp_state_t state_reg;
	spimsp_state_t state_next;
	logic [15:0] div_reg;
	logic [4:0] bit_reg;
	logic sck_reg;
	logic [1:0] sck_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic [1:0] miso_sync_reg;
	logic [1:0] ss_sync_reg;
	logic sck_d_reg;
	logic [15:0] count_reg;
	logic dma_reg;
	logic desc_irq_reg;
	logic irq_word_reg;
	logic irq_desc_reg;
	logic overrun_reg;
	logic rx_push_reg;
	logic [15:0] rx_data_w;
	logic [15:0] tx_fifo_data;
	logic tx_fifo_valid;
	logic tx_pop;
	logic rx_fifo_in_ready;
	logic [15:0] div_eff;
	logic div_hit;
	logic [4:0] word_len;
	logic sck_s;
	logic ss_active;
	logic s_lead;
	logic s_trail;
	logic m_lead;
	logic m_trail;
	logic lead;
	logic trail;
	logic sample;
	logic launch;
	logic start;
	logic load;
	logic word_end;
	logic ser_out;
	logic dma_go;
	logic [15:0] load_word;

	// Divisors below the minimum are clamped so SCK never beats clk/4
	assign div_eff = (baud_div < `SPIMSP_BAUD_MIN) ? `SPIMSP_BAUD_MIN : baud_div;
	assign div_hit = (div_reg == div_eff - 16'h0001);
	assign word_len = cfg.word16 ? `SPIMSP_LEN_16 : `SPIMSP_LEN_8;
	assign sck_s = sck_sync_reg[1] ^ cfg.cpol;
	// Flag zero acts as select only when reconfigured for it
	assign ss_active = flag0_is_select && !ss_sync_reg[1];
	assign s_lead = ss_active && sck_s && !(sck_d_reg ^ cfg.cpol);
	assign s_trail = ss_active && !sck_s && (sck_d_reg ^ cfg.cpol);
	assign m_lead = (state_reg == SPIMSP_LEAD) && div_hit;
	assign m_trail = (state_reg == SPIMSP_TRAIL) && div_hit;
	assign lead = cfg.master ? m_lead : s_lead;
	assign trail = cfg.master ? m_trail : s_trail;
	// Phase 0 samples on the leading edge, phase 1 on the trailing edge
	assign sample = cfg.cpha ? trail : lead;
	assign launch = cfg.cpha ? lead && (bit_reg != 5'h00) : trail;
	assign word_end = cfg.master ? m_trail && (bit_reg == word_len - 5'h01)
		: trail && (bit_reg == word_len - 5'h01);
	assign dma_go = !cfg.dma_en || (dma_reg && count_reg != 16'h0000);
	assign start = cfg.enable && cfg.master && (state_reg == SPIMSP_IDLE)
		&& tx_fifo_valid && dma_go;
	// A slave that underruns reloads zero rather than stale bits
	assign load_word = (tx_fifo_valid && dma_go) ? tx_fifo_data : 16'h0000;
	assign load = start || (!cfg.master && cfg.enable
		&& ((state_reg == SPIMSP_IDLE && ss_active) || (state_reg == SPIMSP_DONE && ss_active)));
	assign tx_pop = load && tx_fifo_valid && dma_go;
	assign busy = (state_reg != SPIMSP_IDLE);
	assign dma_count = count_reg;
	assign dma_busy = dma_reg;
	assign desc_ready = cfg.dma_en && (!dma_reg || count_reg == 16'h0000);
	assign irq_word = irq_word_reg;
	assign irq_desc_done = irq_desc_reg;
	assign rx_overrun = overrun_reg;
	always_comb
	begin
		pins.sck_o = cfg.master ? sck_reg : 1'b0;
		pins.sck_oe = cfg.enable && cfg.master;
		pins.mosi_o = ser_out;
		pins.mosi_oe = cfg.enable && cfg.master;
		pins.miso_o = ser_out;
		pins.miso_oe = cfg.enable && !cfg.master && ss_active;
	end
	// Active-low selects; several may assert together for broadcast
	assign flag_lines_one_to_seven = ~(sel_enable & sel_assert);
	assign flag_lines_one_to_seven_oe = sel_enable & {7{cfg.enable && cfg.master}};

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			SPIMSP_IDLE:
				if (start || load)
					state_next = SPIMSP_LEAD;
			SPIMSP_LEAD:
				if (lead)
					state_next = SPIMSP_TRAIL;
				else if (!cfg.master && !ss_active)
					state_next = SPIMSP_IDLE;
			SPIMSP_TRAIL:
				if (word_end)
					state_next = SPIMSP_DONE;
				else if (trail)
					state_next = SPIMSP_LEAD;
				else if (!cfg.master && !ss_active)
					state_next = SPIMSP_IDLE;
			SPIMSP_DONE:
				state_next = (!cfg.master && ss_active) ? SPIMSP_LEAD : SPIMSP_IDLE;
			default:
				state_next = SPIMSP_IDLE;
		endcase
		if (!cfg.enable)
			state_next = SPIMSP_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sck_sync_reg <= 2'b00;
			mosi_sync_reg <= 2'b00;
			miso_sync_reg <= 2'b00;
			ss_sync_reg <= 2'b11;
			sck_d_reg <= 1'b0;
		end
		else
		begin
			sck_sync_reg <= {sck_sync_reg[0], sck_i};
			mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
			miso_sync_reg <= {miso_sync_reg[0], miso_i};
			ss_sync_reg <= {ss_sync_reg[0], flag_line_zero};
			sck_d_reg <= sck_sync_reg[1];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= SPIMSP_IDLE;
			div_reg <= 16'h0000;
			bit_reg <= 5'h00;
			sck_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			div_reg <= (state_reg == SPIMSP_IDLE || div_hit) ? 16'h0000 : div_reg + 16'h0001;
			if (load)
				bit_reg <= 5'h00;
			else if (trail)
				bit_reg <= bit_reg + 5'h01;
			// Master SCK toggles at each half period, idles at polarity
			if (state_next == SPIMSP_IDLE || state_reg == SPIMSP_IDLE)
				sck_reg <= cfg.cpol;
			else if (m_lead || m_trail)
				sck_reg <= ~sck_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			count_reg <= `SPIMSP_CNT_RESET;
			dma_reg <= 1'b0;
			desc_irq_reg <= 1'b0;
			irq_desc_reg <= 1'b0;
			irq_word_reg <= 1'b0;
			overrun_reg <= 1'b0;
			rx_push_reg <= 1'b0;
		end
		else
		begin
			irq_word_reg <= word_end;
			rx_push_reg <= word_end;
			overrun_reg <= rx_push_reg && !rx_fifo_in_ready;
			irq_desc_reg <= 1'b0;
			if (desc_valid && desc_ready)
			begin
				count_reg <= desc_count;
				dma_reg <= (desc_count != 16'h0000);
				desc_irq_reg <= cfg.dma_rx_irq;
			end
			else if (dma_reg && word_end)
			begin
				count_reg <= count_reg - 16'h0001;
				if (count_reg == 16'h0001)
				begin
					dma_reg <= 1'b0;
					irq_desc_reg <= desc_irq_reg;
				end
			end
		end
	end

	// Master MISO also passes the synchroniser, so clean receive needs a divisor of 3 or more
	spimsp_shifter u_shifter
	(
		.clk(clk),
		.rst_n(rst_n),
		.load(load),
		.load_data(load_word),
		.word16(cfg.word16),
		.sample(sample),
		.launch(launch),
		.serial_in(cfg.master ? miso_sync_reg[1] : mosi_sync_reg[1]),
		.serial_out(ser_out),
		.rx_word(rx_data_w)
	);

	spimsp_fifo #(.WIDTH(`SPIMSP_WORD_W), .DEPTH(`SPIMSP_FIFO_DEPTH), .AW(`SPIMSP_FIFO_AW)) u_tx_fifo
	(
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(tx_fifo_valid),
		.out_ready(tx_pop),
		.out_data(tx_fifo_data)
	);

	spimsp_fifo #(.WIDTH(`SPIMSP_WORD_W), .DEPTH(`SPIMSP_FIFO_DEPTH), .AW(`SPIMSP_FIFO_AW)) u_rx_fifo
	(
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(rx_push_reg),
		.in_ready(rx_fifo_in_ready),
		.in_data(rx_data_w),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);
endmodule : spimsp_port
`default_nettype wire

// ===== verif/spimsp_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module spimsp_slave_model
(
	// Serial side
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso,
	// Format and data
	input wire logic cpol,
	input wire logic cpha,
	input wire logic word16,
	input wire logic [15:0] reply,
	output logic [15:0] got
);
	int unsigned launches = 0;
	logic [3:0] idx;
	logic [15:0] sh;
	assign sh = word16 ? reply : {reply[7:0], 8'h00};
	// Index wraps so that a held select streams the same reply word
	assign idx = 4'(launches - cpha) & (word16 ? 4'hF : 4'h7);
	// Released line shows the inverse so a stale bit never matches
	assign miso = sel_n ? ~sh[4'hF - idx] : sh[4'hF - idx];
	always @(negedge sel_n)
	begin
		launches = 0;
	end
	always @(sck)
	begin
		if (!sel_n && (sck ^ cpol ^ cpha))
		begin
			got = {got[14:0], mosi};
		end
		else if (!sel_n)
		begin
			launches = launches + 1;
		end
	end
endmodule : spimsp_slave_model
`default_nettype wire

// ===== verif/spimsp_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module spimsp_assertions
	import spimsp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire spimsp_cfg_t cfg,
	input wire logic [6:0] sel_enable,
	input wire logic flag0_is_select,
	input wire logic flag_line_zero,
	input wire spimsp_pins_t pins,
	input wire logic busy,
	input wire logic irq_word,
	input wire logic rx_valid,
	input wire logic desc_ready,
	input wire logic [15:0] dma_count,
	input wire logic irq_desc_done,
	input wire logic [6:0] flag_lines_one_to_seven_oe
);
	logic [5:0] edges_reg;
	logic [5:0] edges_next;
	logic sck_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Idle edges from a polarity change are not counted
	assign edges_next = irq_word ? 6'h00 : edges_reg + 6'((pins.sck_o ^ sck_reg) & busy);
	always_ff @(posedge clk)
	begin
		sck_reg <= pins.sck_o;
		edges_reg <= rst_n ? edges_next : 6'h00;
	end
	sequence master_word_end;
		irq_word && cfg.master;
	endsequence
	sequence slave_unselected;
		(cfg.enable && !cfg.master && flag0_is_select && flag_line_zero) [*4];
	endsequence
	sck_idle_a: assert property (
		cfg.enable && cfg.master && !busy && $stable(cfg) |-> pins.sck_o == cfg.cpol)
		else $error("sck not idle");
	sck_owner_a: assert property (
		$stable(cfg) |-> pins.sck_oe == (cfg.enable && cfg.master)) else $error("sck owner");
	select_oe_a: assert property ($stable(cfg) && $stable(sel_enable) |->
		flag_lines_one_to_seven_oe == (sel_enable & {7{cfg.enable & cfg.master}}))
		else $error("select enable");
	sck_rate_a: assert property (
		busy && $changed(pins.sck_o) |=> $stable(pins.sck_o)) else $error("sck too fast");
	pulse_count_a: assert property (
		master_word_end |-> edges_reg + 6'(pins.sck_o ^ sck_reg) == (cfg.word16 ? 6'h20 : 6'h10))
		else $error("edge count");
	miso_release_a: assert property (
		slave_unselected |-> !pins.miso_oe) else $error("miso driven");
	rx_follow_a: assert property (irq_word |=> rx_valid) else $error("rx late");
	desc_refuse_a: assert property (
		dma_count != 16'h0000 |-> !desc_ready) else $error("desc taken");
	desc_irq_a: assert property (
		irq_desc_done |-> dma_count == 16'h0000 && cfg.dma_rx_irq) else $error("desc irq");
endmodule : spimsp_assertions
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
	import spimsp_pkg::*;
	;
	typedef struct packed
	{
		logic [2:0] fmt;
		logic [15:0] div;
		logic [15:0] tx;
		logic [15:0] rep;
	} spimsp_row_t;
	// Format is word16, cpol, cpha
	spimsp_row_t rows [4] = '{'{3'h0, 16'h0004, 16'h00A5, 16'h003C},
		'{3'h5, 16'h0003, 16'hC35A, 16'h9E01}, '{3'h2, 16'h0005, 16'h0081, 16'h00F0},
		'{3'h7, 16'h0004, 16'h8001, 16'h7FFE}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	spimsp_cfg_t cfg = '0;
	logic [15:0] baud_div = 16'h0004;
	logic [6:0] sel_enable = 7'h01;
	logic [6:0] sel_assert = 7'h00;
	logic flag0_is_select = 1'b1;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b0;
	logic desc_valid = 1'b0;
	logic [15:0] tx_data = 16'h0000;
	logic [15:0] desc_count = 16'h0000;
	logic sck_i = 1'b0;
	logic mosi_i = 1'b0;
	logic flag_line_zero = 1'b1;
	logic tx_ready, rx_valid, desc_ready, dma_busy, busy, irq_word, irq_desc_done, rx_overrun;
	logic miso_i, sel_n;
	logic ovr = 1'b0;
	logic [15:0] rx_data, dma_count, got, msk, sword;
	logic [15:0] reply = 16'h0000;
	logic [6:0] flag_lines_one_to_seven, flag_lines_one_to_seven_oe;
	spimsp_pins_t pins;
	int n_mismatch = 0;
	int checked = 0;
	int words = 0;
	int dones = 0;
	int i;
	int j;
	// Pull-up on the select line
	assign sel_n = flag_lines_one_to_seven_oe[0] ? flag_lines_one_to_seven[0] : 1'b1;
	assign msk = cfg.word16 ? 16'hFFFF : 16'h00FF;
	spimsp_port u_dut (.clk, .rst_n, .cfg, .baud_div, .sel_enable, .sel_assert, .flag0_is_select,
		.tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .desc_valid, .desc_ready,
		.desc_count, .dma_count, .dma_busy, .busy, .irq_word, .irq_desc_done, .rx_overrun, .sck_i,
		.mosi_i, .miso_i, .pins, .flag_line_zero, .flag_lines_one_to_seven,
		.flag_lines_one_to_seven_oe);
	spimsp_slave_model u_model (.sck(pins.sck_o), .sel_n(sel_n), .mosi(pins.mosi_o),
		.miso(miso_i), .cpol(cfg.cpol), .cpha(cfg.cpha), .word16(cfg.word16), .reply(reply),
		.got(got));
	initial
	begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		words <= words + int'(irq_word === 1'b1);
		dones <= dones + int'(irq_desc_done === 1'b1);
		ovr <= ovr | (rx_overrun === 1'b1);
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic guard(input int n);
		if (n >= 3000)
		begin
			chk(16'h0001, 16'h0000);
			end_of_test();
		end
	endtask : guard
	task automatic push(input logic [15:0] d);
		int k;
		tx_data = d;
		tx_valid = 1'b1;
		for (k = 0; k < 3000 && tx_ready !== 1'b1; k++)
			@(negedge clk);
		guard(k);
		@(negedge clk);
		tx_valid = 1'b0;
		@(negedge clk);
	endtask : push
	task automatic desc(input logic [15:0] n);
		int k;
		desc_count = n;
		desc_valid = 1'b1;
		for (k = 0; k < 3000 && desc_ready !== 1'b1; k++)
			@(negedge clk);
		guard(k);
		@(negedge clk);
		desc_valid = 1'b0;
	endtask : desc
	task automatic pop(input logic [15:0] e);
		int k;
		for (k = 0; k < 3000 && rx_valid !== 1'b1; k++)
			@(negedge clk);
		guard(k);
		chk(rx_data & msk, e & msk);
		rx_ready = 1'b1;
		@(negedge clk);
		rx_ready = 1'b0;
		@(negedge clk);
	endtask : pop
	task automatic settle;
		int k;
		int q;
		q = 0;
		for (k = 0; k < 3000 && q < 8; k++)
		begin
			@(negedge clk);
			q = busy ? 0 : q + 1;
		end
		guard(k);
	endtask : settle
	// Bench as outside master, slow clock so the input synchronisers keep up
	task automatic frame(input logic [15:0] o, output logic [15:0] r);
		flag_line_zero = 1'b0;
		for (int b = 15; b >= 0; b--)
		begin
			mosi_i = o[b];
			repeat (8) @(negedge clk);
			r[b] = pins.miso_o;
			sck_i = 1'b1;
			repeat (8) @(negedge clk);
			sck_i = 1'b0;
		end
		repeat (8) @(negedge clk);
		chk(16'({pins.sck_oe, pins.mosi_oe, pins.miso_oe}), 16'h0001);
		flag_line_zero = 1'b1;
		mosi_i = ~mosi_i;
	endtask : frame
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk(16'({flag_lines_one_to_seven, rx_valid, busy, dma_busy}), 16'h03F8);
		chk(dma_count, 16'h0000);
		$display("reset done");
		cfg.enable = 1'b1;
		cfg.master = 1'b1;
		foreach (rows[k])
		begin
			repeat (4) @(negedge clk);
			{cfg.word16, cfg.cpol, cfg.cpha} = rows[k].fmt;
			baud_div = rows[k].div;
			reply = rows[k].rep;
			repeat (4) @(negedge clk);
			sel_assert = 7'h01;
			repeat (4) @(negedge clk);
			push(rows[k].tx);
			chk(16'({pins.sck_oe, pins.mosi_oe, pins.miso_oe}), 16'h0006);
			pop(rows[k].rep);
			chk(got & msk, rows[k].tx & msk);
			sel_assert = 7'h00;
			$display("row %0d done", k);
		end
		sel_enable = 7'h7F;
		sel_assert = 7'h05;
		reply = 16'h1234;
		repeat (4) @(negedge clk);
		chk(16'(flag_lines_one_to_seven), 16'h007A);
		tx_data = 16'h0F0F;
		tx_valid = 1'b1;
		for (i = 0; i < 8 && tx_ready === 1'b1; i++)
			@(negedge clk);
		tx_valid = 1'b0;
		chk(16'(tx_ready), 16'h0000);
		settle();
		for (j = 0; j < 4; j++)
			pop(16'h1234);
		chk(16'(i), 16'h0005);
		chk(16'({rx_valid, ovr}), 16'h0001);
		$display("fill done");
		cfg.dma_en = 1'b1;
		cfg.dma_rx_irq = 1'b1;
		for (j = 0; j < 3; j++)
			push(16'h00C0 + 16'(j));
		repeat (4) @(negedge clk);
		chk(16'(busy), 16'h0000);
		i = words;
		desc(16'h0002);
		settle();
		chk(16'(words - i), 16'h0002);
		chk(16'(dones), 16'h0001);
		desc(16'h0001);
		settle();
		chk(16'(words - i), 16'h0003);
		chk(dma_count, 16'h0000);
		for (j = 0; j < 3; j++)
			pop(16'h1234);
		cfg.dma_en = 1'b0;
		$display("dma done");
		sel_assert = 7'h00;
		cfg.master = 1'b0;
		{cfg.word16, cfg.cpol, cfg.cpha} = 3'h4;
		push(16'hA55A);
		flag0_is_select = 1'b0;
		flag_line_zero = 1'b0;
		repeat (8) @(negedge clk);
		chk(16'({busy, pins.miso_oe}), 16'h0000);
		flag_line_zero = 1'b1;
		repeat (4) @(negedge clk);
		flag0_is_select = 1'b1;
		frame(16'h3C96, sword);
		chk(sword, 16'hA55A);
		pop(16'h3C96);
		repeat (8) @(negedge clk);
		frame(16'h6AC3, sword);
		chk(sword, 16'h0000);
		pop(16'h6AC3);
		$display("slave done");
		end_of_test();
	end
endmodule : tb
bind spimsp_port spimsp_assertions u_chk (.clk, .rst_n, .cfg, .sel_enable, .flag0_is_select,
	.flag_line_zero, .pins, .busy, .irq_word, .rx_valid, .desc_ready, .dma_count,
	.irq_desc_done, .flag_lines_one_to_seven_oe);
`default_nettype wire
